// >>> ext_area_pkg.sv
// constants and types shared by the external bus area selector
// assumes a 24-bit byte address whose top three bits name the area
package ext_area_pkg;

	localparam int ADDR_W      = 24;
	localparam int AREA_COUNT  = 8;
	localparam int AREA_W      = 3;
	localparam int AREA_LSB    = 21;
	localparam int PAGE_ROM_LAST = 1;
	localparam int MUXED_FIRST   = 3;

	// fixed internal access: width and cycle count
	localparam int   INT_ACCESS_CYCLES = 1;
	localparam logic INT_WIDTH_16      = 1'b1;

	// reset values of the configuration
	localparam logic [7:0]  PFC_RESET_ROM_OFF = 8'h01;
	localparam logic [7:0]  PFC_RESET_ROM_ON  = 8'h00;
	localparam logic [7:0]  WIDTH_RESET_16    = 8'hFF;
	localparam logic [7:0]  WIDTH_RESET_8     = 8'h00;
	localparam logic [7:0]  SRAM_RESET        = 8'h00;
	localparam logic [7:0]  PAGE_ROM_RESET    = 8'h00;
	localparam logic [7:0]  MUXED_RESET       = 8'h00;
	localparam logic        WAIT_EN_RESET     = 1'b0;
	localparam logic [23:0] ROUTE_RESET       = 24'hFAC688;

	typedef enum logic [1:0] {
		IF_BASIC,
		IF_BYTE_SRAM,
		IF_PAGE_ROM,
		IF_MUXED_IO
	} if_type_e;

endpackage : ext_area_pkg

// >>> sync_2ff.sv
// two flip-flop synchroniser for levels and toggles
// assumes the source is stable for at least two destination edges
module sync_2ff #(
	parameter int          WIDTH     = 1,
	parameter logic [63:0] RESET_VAL = 64'h0
) (
	// destination clock and synchronous active-low reset
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	// asynchronous source and synchronised result
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			meta_q <= RESET_VAL[WIDTH-1:0];
			sync_q <= RESET_VAL[WIDTH-1:0];
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule : sync_2ff

// >>> external_bus_area_select.sv
// area decode, select routing and strobe sequencing of the external bus
// assumes requests on clock_i; pins are timed on link_clk_i, unrelated phase

// Summary of operation
// - top address bits split space into eight areas
// - routed select pin low during its area access
// - enable bits decide select pin output or port
// - rom off: select 0 output, others inputs
// - rom on: all select pins inputs at reset
// - merged selects low when any enabled routed area accessed
// - each area keeps its own bus settings
// - internal accesses fixed width and cycle count
// - four interface types, basic after reset
// - page rom areas 0-1, muxed io 3-7 only
// - per-area width bit picks 8 or 16
// - byte sram areas always sixteen bits wide
// - width reset value follows boot mode
// - bus mode sixteen if any area sixteen
// - unused hold strobe, upper write strobe and select pins left as port inputs
module external_bus_area_select (
	// clocks and reset
	input  wire logic        clock_i,
	input  wire logic        reset_n_i,
	input  wire logic        link_clk_i,
	// mode straps
	input  wire logic        rom_enabled_mode_i,
	input  wire logic        boot_16bit_mode_i,
	// configuration
	input  wire logic        cfg_load_i,
	input  wire logic [7:0]  port_function_ctl_i,
	input  wire logic [23:0] select_route_i,
	input  wire logic [7:0]  area_width_ctl_i,
	input  wire logic [7:0]  byte_sram_select_ctl_i,
	input  wire logic [7:0]  page_rom_ctl_i,
	input  wire logic [7:0]  muxed_io_ctl_i,
	input  wire logic        wait_pin_enable_i,
	// access request and completion
	input  wire logic        req_valid_i,
	input  wire logic        req_internal_i,
	input  wire logic        req_write_i,
	input  wire logic [23:0] req_addr_i,
	input  wire logic [1:0]  req_byte_en_i,
	output logic             busy_o,
	output logic             done_o,
	output logic             done_width16_o,
	output logic [1:0]       done_type_o,
	output logic             bus_mode_16_o,
	// external pins
	input  wire logic        wait_n_i,
	output logic [7:0]       area_select_oe_o,
	output logic [7:0]       area_select_n_o,
	output logic [23:0]      ext_addr_o,
	output logic             address_strobe_n_o,
	output logic             address_strobe_oe_o,
	output logic             address_hold_strobe_n_o,
	output logic             address_hold_strobe_oe_o,
	output logic             read_strobe_n_o,
	output logic             upper_byte_write_strobe_n_o,
	output logic             upper_byte_write_strobe_oe_o,
	output logic             lower_byte_write_strobe_n_o
);

	typedef enum logic [2:0] {
		L_IDLE, L_ADDR, L_T1, L_T2, L_T3, L_END
	} link_state_e;

	// straps and acknowledge crossing into clock_i
	logic rom_en_s, boot16_s, ack_s;
	logic ack_tgl_q, ack_tgl_d;
	sync_2ff #(.WIDTH(3), .RESET_VAL(64'h0)) u_sync_sys (
		.clk_i     (clock_i),
		.reset_n_i (reset_n_i),
		.async_i   ({rom_enabled_mode_i, boot_16bit_mode_i, ack_tgl_q}),
		.sync_o    ({rom_en_s, boot16_s, ack_s})
	);

	// configuration registers; defaults apply until the first load
	logic        cfg_loaded_q, cfg_loaded_d;
	logic [7:0]  pfc_q, pfc_d, width_q, width_d, sram_q, sram_d;
	logic [7:0]  prom_q, prom_d, mux_q, mux_d;
	logic [23:0] route_q, route_d;
	logic        wait_en_q, wait_en_d;
	logic [7:0]  pfc_eff, width_eff, sram_eff, prom_eff, mux_eff;
	logic [23:0] route_eff;
	logic        wait_en_eff;

	always_comb begin
		if (cfg_loaded_q) begin
			pfc_eff     = pfc_q;
			width_eff   = width_q;
			sram_eff    = sram_q;
			prom_eff    = prom_q;
			mux_eff     = mux_q;
			route_eff   = route_q;
			wait_en_eff = wait_en_q;
		end else begin
			pfc_eff     = rom_en_s ? ext_area_pkg::PFC_RESET_ROM_ON
			                       : ext_area_pkg::PFC_RESET_ROM_OFF;
			width_eff   = boot16_s ? ext_area_pkg::WIDTH_RESET_16
			                       : ext_area_pkg::WIDTH_RESET_8;
			sram_eff    = ext_area_pkg::SRAM_RESET;
			prom_eff    = ext_area_pkg::PAGE_ROM_RESET;
			mux_eff     = ext_area_pkg::MUXED_RESET;
			route_eff   = ext_area_pkg::ROUTE_RESET;
			wait_en_eff = ext_area_pkg::WAIT_EN_RESET;
		end
	end

	// per-area interface type and width, per-pin routing
	ext_area_pkg::if_type_e type_eff [ext_area_pkg::AREA_COUNT];
	logic [7:0] w16_eff;
	logic [7:0] req_onehot;
	logic [7:0] oe_comb, req_pins;
	logic [7:0] route_hit [ext_area_pkg::AREA_COUNT];

	// area number is the top three address bits
	assign req_onehot = 8'h01 << req_addr_i[23:ext_area_pkg::AREA_LSB];

	for (genvar a = 0; a < ext_area_pkg::AREA_COUNT; a++) begin : g_area
		// unsupported type bits are ignored, not honoured
		assign type_eff[a] =
			(a <= ext_area_pkg::PAGE_ROM_LAST && prom_eff[a])
				? ext_area_pkg::IF_PAGE_ROM :
			(a >= ext_area_pkg::MUXED_FIRST && mux_eff[a])
				? ext_area_pkg::IF_MUXED_IO :
			sram_eff[a] ? ext_area_pkg::IF_BYTE_SRAM
			            : ext_area_pkg::IF_BASIC;
		assign w16_eff[a] = (type_eff[a] == ext_area_pkg::IF_BYTE_SRAM)
		                    || width_eff[a];

		property p_sram_16;
			@(posedge clock_i) disable iff (!reset_n_i)
			(type_eff[a] == ext_area_pkg::IF_BYTE_SRAM) |-> w16_eff[a];
		endproperty
		a_sram_16: assert property (p_sram_16)
			else $error("byte sram area not sixteen bits");

		property p_reset_basic;
			@(posedge clock_i) disable iff (!reset_n_i)
			!cfg_loaded_q |-> (type_eff[a] == ext_area_pkg::IF_BASIC);
		endproperty
		a_reset_basic: assert property (p_reset_basic)
			else $error("area not basic type before configuration");
	end

	for (genvar p = 0; p < ext_area_pkg::AREA_COUNT; p++) begin : g_pin
		localparam logic [2:0] PIN = p;
		for (genvar a = 0; a < ext_area_pkg::AREA_COUNT; a++) begin : g_src
			assign route_hit[p][a] = (route_eff[a*3 +: 3] == PIN);
		end
		// a pin drives if any enabled area is routed to it
		assign oe_comb[p]  = |(pfc_eff & route_hit[p]);
		assign req_pins[p] = |(pfc_eff & route_hit[p] & req_onehot);
	end

	// request side state
	logic        busy_q, busy_d, int_q, int_d, done_q, done_d;
	logic        cnt_q, cnt_d;
	logic        req_tgl_q, req_tgl_d, ack_seen_q, ack_seen_d;
	logic [23:0] snap_addr_q, snap_addr_d;
	logic        snap_write_q, snap_write_d, snap_w16_q, snap_w16_d;
	logic        snap_wait_q, snap_wait_d;
	logic [1:0]  snap_be_q, snap_be_d;
	ext_area_pkg::if_type_e snap_type_q, snap_type_d;
	logic [7:0]  snap_pins_q, snap_pins_d;
	logic        dw16_q, dw16_d;
	logic [1:0]  dtype_q, dtype_d;
	logic [7:0]  oe_q;
	logic        bus16_q, upper_oe_q, ah_oe_q;

	always_comb begin
		cfg_loaded_d = cfg_loaded_q | cfg_load_i;
		pfc_d     = cfg_load_i ? port_function_ctl_i    : pfc_q;
		width_d   = cfg_load_i ? area_width_ctl_i       : width_q;
		sram_d    = cfg_load_i ? byte_sram_select_ctl_i : sram_q;
		prom_d    = cfg_load_i ? page_rom_ctl_i         : prom_q;
		mux_d     = cfg_load_i ? muxed_io_ctl_i         : mux_q;
		route_d   = cfg_load_i ? select_route_i         : route_q;
		wait_en_d = cfg_load_i ? wait_pin_enable_i      : wait_en_q;
		busy_d = busy_q;
		int_d  = int_q;
		cnt_d  = cnt_q;
		done_d = 1'b0;
		dw16_d = dw16_q;
		dtype_d = dtype_q;
		req_tgl_d  = req_tgl_q;
		ack_seen_d = ack_s;
		snap_addr_d  = snap_addr_q;
		snap_write_d = snap_write_q;
		snap_w16_d   = snap_w16_q;
		snap_wait_d  = snap_wait_q;
		snap_be_d    = snap_be_q;
		snap_type_d  = snap_type_q;
		snap_pins_d  = snap_pins_q;
		if (busy_q) begin
			if (int_q) begin
				// fixed internal timing, no external settings used
				if (cnt_q == 1'b0) begin
					busy_d  = 1'b0;
					done_d  = 1'b1;
					dw16_d  = ext_area_pkg::INT_WIDTH_16;
					dtype_d = ext_area_pkg::IF_BASIC;
				end else begin
					cnt_d = 1'b0;
				end
			end else if (ack_s != ack_seen_q) begin
				busy_d  = 1'b0;
				done_d  = 1'b1;
				dw16_d  = snap_w16_q;
				dtype_d = snap_type_q;
			end
		end else if (req_valid_i) begin
			busy_d = 1'b1;
			int_d  = req_internal_i;
			cnt_d  = 1'(ext_area_pkg::INT_ACCESS_CYCLES - 1);
			if (!req_internal_i) begin
				// snapshot is held stable until the acknowledge returns
				snap_addr_d  = req_addr_i;
				snap_write_d = req_write_i;
				snap_be_d    = req_byte_en_i;
				snap_type_d  = type_eff[req_addr_i[23:ext_area_pkg::AREA_LSB]];
				snap_w16_d   = w16_eff[req_addr_i[23:ext_area_pkg::AREA_LSB]];
				snap_wait_d  = wait_en_eff;
				snap_pins_d  = req_pins;
				req_tgl_d    = ~req_tgl_q;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			cfg_loaded_q <= 1'b0;
			pfc_q <= 8'h00;
			width_q <= 8'h00;
			sram_q <= 8'h00;
			prom_q <= 8'h00;
			mux_q <= 8'h00;
			route_q <= 24'h000000;
			wait_en_q <= 1'b0;
			busy_q <= 1'b0;
			int_q <= 1'b0;
			cnt_q <= 1'b0;
			done_q <= 1'b0;
			dw16_q <= 1'b0;
			dtype_q <= 2'h0;
			req_tgl_q <= 1'b0;
			ack_seen_q <= 1'b0;
			snap_addr_q <= 24'h000000;
			snap_write_q <= 1'b0;
			snap_w16_q <= 1'b0;
			snap_wait_q <= 1'b0;
			snap_be_q <= 2'h0;
			snap_type_q <= ext_area_pkg::IF_BASIC;
			snap_pins_q <= 8'h00;
			oe_q <= 8'h00;
			bus16_q <= 1'b0;
			upper_oe_q <= 1'b0;
			ah_oe_q <= 1'b0;
		end else begin
			cfg_loaded_q <= cfg_loaded_d;
			pfc_q <= pfc_d;
			width_q <= width_d;
			sram_q <= sram_d;
			prom_q <= prom_d;
			mux_q <= mux_d;
			route_q <= route_d;
			wait_en_q <= wait_en_d;
			busy_q <= busy_d;
			int_q <= int_d;
			cnt_q <= cnt_d;
			done_q <= done_d;
			dw16_q <= dw16_d;
			dtype_q <= dtype_d;
			req_tgl_q <= req_tgl_d;
			ack_seen_q <= ack_seen_d;
			snap_addr_q <= snap_addr_d;
			snap_write_q <= snap_write_d;
			snap_w16_q <= snap_w16_d;
			snap_wait_q <= snap_wait_d;
			snap_be_q <= snap_be_d;
			snap_type_q <= snap_type_d;
			snap_pins_q <= snap_pins_d;
			oe_q <= oe_comb;
			bus16_q <= |w16_eff;
			upper_oe_q <= |w16_eff;
			ah_oe_q <= |(mux_eff & 8'hF8);
		end
	end

	// link domain: reset, request toggle and wait pin crossings
	logic lrst_n, req_s, wait_n_s;
	sync_2ff #(.WIDTH(1), .RESET_VAL(64'h0)) u_sync_rst (
		.clk_i     (link_clk_i),
		.reset_n_i (1'b1),
		.async_i   (reset_n_i),
		.sync_o    (lrst_n)
	);
	sync_2ff #(.WIDTH(2), .RESET_VAL(64'h1)) u_sync_link (
		.clk_i     (link_clk_i),
		.reset_n_i (lrst_n),
		.async_i   ({req_tgl_q, wait_n_i}),
		.sync_o    ({req_s, wait_n_s})
	);

	link_state_e lstate_q, lstate_d;
	logic        req_prev_q, req_prev_d;
	logic [7:0]  sel_n_q, sel_n_d;
	logic [23:0] eaddr_q, eaddr_d;
	logic        as_n_q, as_n_d, ah_n_q, ah_n_d, rd_n_q, rd_n_d;
	logic        uw_n_q, uw_n_d, lw_n_q, lw_n_d;
	logic        is_mux, lanes_on;

	assign is_mux   = (snap_type_q == ext_area_pkg::IF_MUXED_IO);
	// byte sram lanes strobe on reads too
	assign lanes_on = snap_write_q || (snap_type_q == ext_area_pkg::IF_BYTE_SRAM);

	always_comb begin
		lstate_d   = lstate_q;
		req_prev_d = req_prev_q;
		ack_tgl_d  = ack_tgl_q;
		sel_n_d = sel_n_q;
		eaddr_d = eaddr_q;
		as_n_d  = as_n_q;
		ah_n_d  = ah_n_q;
		rd_n_d  = rd_n_q;
		uw_n_d  = uw_n_q;
		lw_n_d  = lw_n_q;
		unique case (lstate_q)
			L_IDLE: begin
				if (req_s != req_prev_q) begin
					req_prev_d = req_s;
					eaddr_d    = snap_addr_q;
					if (is_mux) begin
						ah_n_d   = 1'b0;
						lstate_d = L_ADDR;
					end else begin
						as_n_d   = 1'b0;
						sel_n_d  = ~snap_pins_q;
						lstate_d = L_T1;
					end
				end
			end
			L_ADDR: begin
				ah_n_d   = 1'b1;
				sel_n_d  = ~snap_pins_q;
				lstate_d = L_T1;
			end
			L_T1: begin
				rd_n_d   = snap_write_q;
				lw_n_d   = ~(lanes_on && snap_be_q[0]);
				uw_n_d   = ~(lanes_on && snap_be_q[1] && snap_w16_q);
				lstate_d = L_T2;
			end
			L_T2: begin
				// wait pin lags two link edges: sample it a state later
				lstate_d = L_T3;
			end
			L_T3: begin
				// hold the access while the wait pin is low and the wait pin is enabled
				if (!(snap_wait_q && !wait_n_s)) begin
					sel_n_d  = 8'hFF;
					as_n_d   = 1'b1;
					rd_n_d   = 1'b1;
					uw_n_d   = 1'b1;
					lw_n_d   = 1'b1;
					lstate_d = L_END;
				end
			end
			L_END: begin
				ack_tgl_d = ~ack_tgl_q;
				lstate_d  = L_IDLE;
			end
		endcase
	end

	always_ff @(posedge link_clk_i) begin
		if (!lrst_n) begin
			lstate_q <= L_IDLE;
			req_prev_q <= 1'b0;
			ack_tgl_q <= 1'b0;
			sel_n_q <= 8'hFF;
			eaddr_q <= 24'h000000;
			as_n_q <= 1'b1;
			ah_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			uw_n_q <= 1'b1;
			lw_n_q <= 1'b1;
		end else begin
			lstate_q <= lstate_d;
			req_prev_q <= req_prev_d;
			ack_tgl_q <= ack_tgl_d;
			sel_n_q <= sel_n_d;
			eaddr_q <= eaddr_d;
			as_n_q <= as_n_d;
			ah_n_q <= ah_n_d;
			rd_n_q <= rd_n_d;
			uw_n_q <= uw_n_d;
			lw_n_q <= lw_n_d;
		end
	end

	assign busy_o = busy_q;
	assign done_o = done_q;
	assign done_width16_o = dw16_q;
	assign done_type_o = dtype_q;
	assign bus_mode_16_o = bus16_q;
	assign area_select_oe_o = oe_q;
	assign area_select_n_o = sel_n_q;
	assign ext_addr_o = eaddr_q;
	assign address_strobe_n_o = as_n_q;
	assign address_strobe_oe_o = lrst_n;
	assign address_hold_strobe_n_o = ah_n_q;
	assign address_hold_strobe_oe_o = ah_oe_q;
	assign read_strobe_n_o = rd_n_q;
	assign upper_byte_write_strobe_n_o = uw_n_q;
	assign upper_byte_write_strobe_oe_o = upper_oe_q;
	assign lower_byte_write_strobe_n_o = lw_n_q;

	property p_rom_off_oe;
		@(posedge clock_i) disable iff (!reset_n_i)
		(!cfg_loaded_q && !rom_en_s) |=> (area_select_oe_o == 8'h01);
	endproperty
	a_rom_off_oe: assert property (p_rom_off_oe)
		else $error("rom off reset select enables wrong");

	property p_rom_on_oe;
		@(posedge clock_i) disable iff (!reset_n_i)
		(!cfg_loaded_q && rom_en_s) |=> (area_select_oe_o == 8'h00);
	endproperty
	a_rom_on_oe: assert property (p_rom_on_oe)
		else $error("rom on reset select pins not inputs");

	property p_disabled_port;
		@(posedge clock_i) disable iff (!reset_n_i)
		(cfg_loaded_q && pfc_q == 8'h00) |=> (area_select_oe_o == 8'h00);
	endproperty
	a_disabled_port: assert property (p_disabled_port)
		else $error("disabled select pin still driven");

	property p_bus_mode;
		@(posedge clock_i) disable iff (!reset_n_i)
		(w16_eff == 8'h00) |=> (!bus_mode_16_o && !upper_byte_write_strobe_oe_o);
	endproperty
	a_bus_mode: assert property (p_bus_mode)
		else $error("eight bit bus mode not set");

	property p_bus_mode16;
		@(posedge clock_i) disable iff (!reset_n_i)
		(w16_eff != 8'h00) |=> bus_mode_16_o;
	endproperty
	a_bus_mode16: assert property (p_bus_mode16)
		else $error("sixteen bit bus mode not set");

	sequence s_int_take;
		req_valid_i && req_internal_i && !busy_o;
	endsequence
	property p_internal_fixed;
		@(posedge clock_i) disable iff (!reset_n_i)
		s_int_take |=> (!done_o && $stable(req_tgl_q)) ##1
			(done_o && done_width16_o && $stable(req_tgl_q));
	endproperty
	a_internal_fixed: assert property (p_internal_fixed)
		else $error("internal access timing not fixed");

	property p_area2_types;
		@(posedge clock_i) disable iff (!reset_n_i)
		type_eff[2] inside {ext_area_pkg::IF_BASIC, ext_area_pkg::IF_BYTE_SRAM};
	endproperty
	a_area2_types: assert property (p_area2_types)
		else $error("area 2 has a forbidden interface type");

	sequence s_plain_start;
		lstate_q == L_IDLE && req_s != req_prev_q && !is_mux;
	endsequence
	sequence s_plain_select;
		(lstate_q == L_T1 && !address_strobe_n_o && address_hold_strobe_n_o)
		##1 (lstate_q == L_T2 && area_select_n_o == ~snap_pins_q);
	endsequence
	property p_select_seq;
		@(posedge link_clk_i) disable iff (!lrst_n)
		s_plain_start |=> s_plain_select;
	endproperty
	a_select_seq: assert property (p_select_seq)
		else $error("select or address strobe sequence wrong");

	property p_hold_muxed;
		@(posedge link_clk_i) disable iff (!lrst_n)
		!address_hold_strobe_n_o |-> (is_mux && address_strobe_n_o);
	endproperty
	a_hold_muxed: assert property (p_hold_muxed)
		else $error("hold strobe outside muxed access");

endmodule : external_bus_area_select

// >>> ext_device_model.sv
// model of the external memory and peripheral chips on the bus pins
// assumes pins are timed on the link clock; the wait pin has a pull-up
module ext_device_model #(
	parameter int STALL = 40
) (
	// link clock and bench controls
	input  wire logic       link_clk_i,
	input  wire logic       clr_i,
	input  wire logic       stall_en_i,
	// pins to and from the device
	input  wire logic [7:0] area_select_n_i,
	input  wire logic       address_strobe_n_i,
	input  wire logic       address_hold_strobe_n_i,
	input  wire logic       read_strobe_n_i,
	input  wire logic       upper_byte_write_strobe_n_i,
	input  wire logic       lower_byte_write_strobe_n_i,
	output logic            wait_n_o,
	// low levels seen since the last clear: {hold, as, rd, upper, lower}
	output logic [7:0]      sel_seen_o,
	output logic [4:0]      strobe_seen_o
);
	timeunit 1ns;
	timeprecision 100ps;

	logic       frame;
	logic [4:0] strobes_n;
	int         cnt = 0;

	assign strobes_n = {address_hold_strobe_n_i, address_strobe_n_i,
		read_strobe_n_i, upper_byte_write_strobe_n_i,
		lower_byte_write_strobe_n_i};
	assign frame = ~&area_select_n_i | ~&strobes_n;
	// slow chip holds wait from the start of the frame
	assign wait_n_o = !(stall_en_i && frame && cnt < STALL);

	always @(posedge link_clk_i) begin
		cnt <= frame ? cnt + 1 : 0;
		if (clr_i) begin
			sel_seen_o    <= 8'hFF;
			strobe_seen_o <= 5'h00;
		end else begin
			sel_seen_o    <= sel_seen_o & area_select_n_i;
			strobe_seen_o <= strobe_seen_o | ~strobes_n;
		end
	end
endmodule : ext_device_model

// >>> external_bus_area_select_test.sv
// self-checking bench for the external bus area selector
// assumes the external device model answers on the pins
module external_bus_area_select_test;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clock_i = 0, link_clk_i = 0, reset_n_i = 0;
	logic        rom_on = 0, boot16 = 0, cfg_load = 0, wait_en = 0;
	logic [7:0]  pfc = 0, width = 0, sram = 0, prom = 0, mux = 0;
	logic [23:0] route = 24'hFAC688, addr = 0, eaddr;
	logic        valid = 0, internal = 0, write = 0, clr = 0, stall = 0;
	logic [1:0]  be = 0, done_type;
	logic        busy, done, done_w16, mode16, wait_n;
	logic [7:0]  sel_oe, sel_n, sel_seen;
	logic [4:0]  seen;
	logic        as_n, as_oe, ah_n, ah_oe, rd_n, up_n, up_oe, lo_n;
	int          err_count = 0, check_count = 0, lat;

	initial forever #12.5 clock_i = ~clock_i;
	// unrelated phase to the system clock
	initial begin
		#1.3;
		forever #3 link_clk_i = ~link_clk_i;
	end

	external_bus_area_select external_bus_area_select_i (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .link_clk_i(link_clk_i),
		.rom_enabled_mode_i(rom_on), .boot_16bit_mode_i(boot16),
		.cfg_load_i(cfg_load), .port_function_ctl_i(pfc),
		.select_route_i(route), .area_width_ctl_i(width),
		.byte_sram_select_ctl_i(sram), .page_rom_ctl_i(prom),
		.muxed_io_ctl_i(mux), .wait_pin_enable_i(wait_en),
		.req_valid_i(valid), .req_internal_i(internal), .req_write_i(write),
		.req_addr_i(addr), .req_byte_en_i(be), .busy_o(busy), .done_o(done),
		.done_width16_o(done_w16), .done_type_o(done_type),
		.bus_mode_16_o(mode16), .wait_n_i(wait_n), .area_select_oe_o(sel_oe),
		.area_select_n_o(sel_n), .ext_addr_o(eaddr), .address_strobe_n_o(as_n),
		.address_strobe_oe_o(as_oe), .address_hold_strobe_n_o(ah_n),
		.address_hold_strobe_oe_o(ah_oe), .read_strobe_n_o(rd_n),
		.upper_byte_write_strobe_n_o(up_n),
		.upper_byte_write_strobe_oe_o(up_oe),
		.lower_byte_write_strobe_n_o(lo_n));

	ext_device_model ext_device_model_i (
		.link_clk_i(link_clk_i), .clr_i(clr), .stall_en_i(stall),
		.area_select_n_i(sel_n), .address_strobe_n_i(as_n),
		.address_hold_strobe_n_i(ah_n), .read_strobe_n_i(rd_n),
		.upper_byte_write_strobe_n_i(up_n),
		.lower_byte_write_strobe_n_i(lo_n), .wait_n_o(wait_n),
		.sel_seen_o(sel_seen), .strobe_seen_o(seen));

	task automatic check(input string name, input logic [23:0] got,
		input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results

	// every task starts and ends just after a rising clock edge
	task automatic do_reset(input logic rom, input logic b16);
		rom_on = rom;
		boot16 = b16;
		reset_n_i = 0;
		repeat (10) @(posedge clock_i);
		#1 reset_n_i = 1;
		repeat (4) @(posedge clock_i);
		#1;
	endtask : do_reset

	task automatic load(input logic [7:0] p, input logic [23:0] r,
		input logic [7:0] w, input logic [7:0] s, input logic [7:0] b,
		input logic [7:0] m, input logic we);
		{pfc, route, width, sram, prom, mux, wait_en} = {p, r, w, s, b, m, we};
		cfg_load = 1;
		@(posedge clock_i);
		#1 cfg_load = 0;
		@(posedge clock_i);
		#1;
	endtask : load

	task automatic access(input logic in, input logic wr, input logic [2:0] a,
		input logic [1:0] lanes);
		{internal, write, addr, be} = {in, wr, a, 21'h000100, lanes};
		clr = 1;
		@(posedge clock_i);
		#1 clr = 0;
		valid = 1;
		@(posedge clock_i);
		#1 valid = 0;
		check("busy", busy, 1'b1);
		lat = 0;
		while (done !== 1'b1 && lat < 300) begin
			@(posedge clock_i);
			#1 lat++;
		end
		check("done_seen", done, 1'b1);
	endtask : access

	task automatic t_reset_defaults();
		do_reset(0, 0);
		check("oe_rom_off", sel_oe, 8'h01);
		check("mode_8", mode16, 1'b0);
		check("upper_oe_8", up_oe, 1'b0);
		check("hold_oe", ah_oe, 1'b0);
		access(0, 0, 3'h0, 2'h3);
		check("type_basic", done_type, 2'h0);
		check("width_8", done_w16, 1'b0);
		check("sel_area0", sel_seen, 8'hFE);
		check("strobes", seen[4:2], 3'h3);
		do_reset(1, 1);
		check("oe_rom_on", sel_oe, 8'h00);
		check("mode_16", mode16, 1'b1);
		check("upper_oe_16", up_oe, 1'b1);
		access(0, 0, 3'h2, 2'h3);
		check("type_basic2", done_type, 2'h0);
		check("width_16", done_w16, 1'b1);
		$display("test reset_defaults done");
	endtask : t_reset_defaults

	task automatic t_merged_selects();
		// areas 5 and 6 share pin 5
		load(8'hE0, 24'hF6C688, 8'h00, 8'h00, 8'h00, 8'h00, 0);
		// pin 6 has no area routed to it, so it stays a port
		check("oe_enables", sel_oe, 8'hA0);
		check("mode_all8", mode16, 1'b0);
		for (int a = 5; a < 8; a++) begin
			access(0, 0, 3'(a), 2'h3);
			check("sel_pin", sel_seen, (a == 7) ? 8'h7F : 8'hDF);
		end
		load(8'h00, 24'hFAC688, 8'h00, 8'h00, 8'h00, 8'h00, 0);
		check("oe_none", sel_oe, 8'h00);
		access(0, 0, 3'h5, 2'h3);
		check("sel_none", sel_seen, 8'hFF);
		$display("test merged_selects done");
	endtask : t_merged_selects

	task automatic t_types_width();
		logic [1:0] ty;
		load(8'hFF, 24'hFAC688, 8'h00, 8'hFF, 8'hFF, 8'hFF, 0);
		check("hold_oe_mux", ah_oe, 1'b1);
		for (int a = 0; a < 8; a++) begin
			ty = (a < 2) ? 2'h2 : (a == 2) ? 2'h1 : 2'h3;
			access(0, 0, 3'(a), 2'h3);
			check("area_type", done_type, ty);
			check("area_width", done_w16, a == 2);
			check("sel_decode", sel_seen, 8'(~(8'h01 << a)));
			check("ext_addr", eaddr, {3'(a), 21'h000100});
			check("as_used", seen[3], ty != 2'h3);
			check("hold_used", seen[4], ty == 2'h3);
		end
		load(8'hFF, 24'hFAC688, 8'h00, 8'h00, 8'h00, 8'h00, 0);
		access(0, 1, 3'h3, 2'h3);
		check("upper_8bit", seen[1:0], 2'h1);
		check("upper_oe_off", up_oe, 1'b0);
		load(8'hFF, 24'hFAC688, 8'h10, 8'h00, 8'h00, 8'h00, 0);
		check("mode_one16", mode16, 1'b1);
		access(0, 1, 3'h4, 2'h3);
		check("width_a4", done_w16, 1'b1);
		check("upper_16bit", seen[1:0], 2'h3);
		access(0, 0, 3'h3, 2'h3);
		check("width_a3", done_w16, 1'b0);
		$display("test types_width done");
	endtask : t_types_width

	task automatic t_internal();
		access(1, 0, 3'h0, 2'h3);
		check("int_latency", lat, 24'(ext_area_pkg::INT_ACCESS_CYCLES));
		check("int_width", done_w16, 1'b1);
		check("int_type", done_type, 2'h0);
		check("int_no_pins", sel_seen, 8'hFF);
		$display("test internal done");
	endtask : t_internal

	task automatic t_wait();
		int plain;
		load(8'hFF, 24'hFAC688, 8'h00, 8'h00, 8'h00, 8'h00, 1);
		access(0, 0, 3'h2, 2'h3);
		plain = lat;
		stall = 1;
		access(0, 0, 3'h2, 2'h3);
		check("wait_stretch", lat >= plain + 8, 1'b1);
		load(8'hFF, 24'hFAC688, 8'h00, 8'h00, 8'h00, 8'h00, 0);
		access(0, 0, 3'h2, 2'h3);
		check("wait_ignored", lat <= plain + 1, 1'b1);
		stall = 0;
		$display("test wait done");
	endtask : t_wait

	initial begin
		repeat (20000) @(posedge clock_i);
		err_count++;
		results();
	end

	initial begin
		t_reset_defaults();
		t_merged_selects();
		t_types_width();
		t_internal();
		t_wait();
		results();
	end
endmodule : external_bus_area_select_test
